// ===== core/charge_gauge_digital_core.sv
`timescale 1ns/1ns
`include "charge_gauge_defines.svh"
module charge_gauge_digital_core #(
	parameter int unsigned AUTO_PERIOD_CYCLES = `AUTO_PERIOD_CYC,
	// identity bit value is arbitrary
	parameter logic CHIP_ID = 1'b1
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic ALERT_IN,
	output logic ALERT_OUT,
	output logic ALERT_OE,
	input wire logic INTEG_STEP,
	input wire logic SWITCH_ONE,
	input wire logic RAMP_UP,
	input wire logic UNDERVOLTAGE_LOCKOUT,
	output logic ADC_START,
	output logic ADC_TEMP,
	input wire logic ADC_DONE,
	input wire logic [15:0] ADC_DATA,
	output logic ANALOG_OFF
);
	import charge_gauge_pkg::*;

	generate
		if (AUTO_PERIOD_CYCLES < 2) begin : g_bad
			$error("auto period too short");
		end
	endgenerate

	// ==================================================
	// register storage
	logic [7:0] ctrl_reg;
	logic [15:0] acr_reg, chi_reg, clo_reg, volt_reg, temp_reg;
	logic [7:0] vhi_reg, vlo_reg, thi_reg, tlo_reg;
	logic [5:0] flags_reg;
	logic alert_reg, sat_reg;
	adc_mode_t adc_mode;
	pin_mode_t pin_mode;
	logic shdn;
	assign adc_mode = adc_mode_t'(ctrl_reg[7:6]);
	assign pin_mode = pin_mode_t'(ctrl_reg[2:1]);
	assign shdn = ctrl_reg[`SHDN_BIT];

	// ==================================================
	// serial port
	i2c_state_t st;
	logic scl_q, sda_q, oe_reg, rw_reg, ara_reg, acked_reg;
	logic [7:0] sr_reg, tx_reg, snap_reg, hold_reg;
	logic [3:0] bitcnt_reg, ptr_reg, snap_addr, hold_addr, wr_addr;
	logic snap_ok, hold_ok, wr_pulse;
	logic [7:0] wr_data;
	logic scl_rise, scl_fall, start_c, stop_c, load_byte, status_rd;
	logic [7:0] tx_src;

	// both lines sampled as plain synchronous inputs; the device never drives the clock line
	assign scl_rise = SCL & ~scl_q;
	assign scl_fall = ~SCL & scl_q;
	assign start_c = scl_q & SCL & sda_q & ~SDA_IN;
	assign stop_c = scl_q & SCL & ~sda_q & SDA_IN;
	assign load_byte = scl_fall & ((st == I2C_AACK & rw_reg) | (st == I2C_RACK & acked_reg & ~ara_reg));
	assign status_rd = load_byte & ~ara_reg & ptr_reg == `OFS_STATUS;

	function automatic logic [7:0] rd_mux(input logic [3:0] a);
		case (a)
			`OFS_STATUS: rd_mux = {CHIP_ID, 1'b0, flags_reg};
			`OFS_CTRL: rd_mux = ctrl_reg;
			`OFS_ACR_H: rd_mux = acr_reg[15:8];
			`OFS_ACR_L: rd_mux = acr_reg[7:0];
			`OFS_CHI_H: rd_mux = chi_reg[15:8];
			`OFS_CHI_L: rd_mux = chi_reg[7:0];
			`OFS_CLO_H: rd_mux = clo_reg[15:8];
			`OFS_CLO_L: rd_mux = clo_reg[7:0];
			`OFS_VOLT_H: rd_mux = volt_reg[15:8];
			`OFS_VOLT_L: rd_mux = volt_reg[7:0];
			`OFS_VHI: rd_mux = vhi_reg;
			`OFS_VLO: rd_mux = vlo_reg;
			`OFS_TEMP_H: rd_mux = temp_reg[15:8];
			`OFS_TEMP_L: rd_mux = temp_reg[7:0];
			`OFS_THI: rd_mux = thi_reg;
			default: rd_mux = tlo_reg;
		endcase
	endfunction

	// low byte comes from the snapshot taken with its high byte
	always_comb begin
		if (ara_reg)
			tx_src = `ARA_REPLY;
		else if (ptr_reg[0] && snap_ok && snap_addr == ptr_reg)
			tx_src = snap_reg;
		else
			tx_src = rd_mux(ptr_reg);
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= SCL;
			sda_q <= SDA_IN;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			st <= I2C_IDLE;
			oe_reg <= 1'b0;
			rw_reg <= 1'b0;
			ara_reg <= 1'b0;
			acked_reg <= 1'b0;
			sr_reg <= 8'h00;
			tx_reg <= 8'h00;
			bitcnt_reg <= 4'h0;
			ptr_reg <= 4'h0;
			wr_pulse <= 1'b0;
			wr_addr <= 4'h0;
			wr_data <= 8'h00;
		end else begin
			wr_pulse <= 1'b0;
			if (start_c) begin
				st <= I2C_ADDR;
				bitcnt_reg <= 4'h0;
				oe_reg <= 1'b0;
				ara_reg <= 1'b0;
			end else if (stop_c) begin
				st <= I2C_IDLE;
				oe_reg <= 1'b0;
			end else if (load_byte) begin
				st <= I2C_RDATA;
				tx_reg <= tx_src;
				oe_reg <= ~tx_src[7];
				bitcnt_reg <= 4'h0;
				if (!ara_reg)
					ptr_reg <= ptr_reg + 4'h1;
			end else begin
				case (st)
					I2C_ADDR, I2C_PTR, I2C_WDATA: begin
						if (scl_rise) begin
							sr_reg <= {sr_reg[6:0], SDA_IN};
							bitcnt_reg <= bitcnt_reg + 4'h1;
						end else if (scl_fall && bitcnt_reg == 4'h8) begin
							bitcnt_reg <= 4'h0;
							oe_reg <= 1'b1;
							if (st == I2C_PTR) begin
								ptr_reg <= sr_reg[3:0];
								st <= I2C_PACK;
							end else if (st == I2C_WDATA) begin
								wr_pulse <= 1'b1;
								wr_addr <= ptr_reg;
								wr_data <= sr_reg;
								ptr_reg <= ptr_reg + 4'h1;
								st <= I2C_WACK;
							end else if (sr_reg[7:1] == `DEV_ADDR) begin
								rw_reg <= sr_reg[0];
								st <= I2C_AACK;
							end else if (sr_reg[7:1] == `ARA_ADDR && sr_reg[0] && alert_reg) begin
								rw_reg <= 1'b1;
								ara_reg <= 1'b1;
								st <= I2C_AACK;
							end else begin
								oe_reg <= 1'b0;
								st <= I2C_IDLE;
							end
						end
					end
					I2C_AACK: begin
						if (scl_fall) begin
							oe_reg <= 1'b0;
							st <= I2C_PTR;
						end
					end
					I2C_PACK, I2C_WACK: begin
						if (scl_fall) begin
							oe_reg <= 1'b0;
							st <= I2C_WDATA;
						end
					end
					I2C_RDATA: begin
						if (scl_rise)
							bitcnt_reg <= bitcnt_reg + 4'h1;
						else if (scl_fall && bitcnt_reg == 4'h8) begin
							oe_reg <= 1'b0;
							st <= I2C_RACK;
						end else if (scl_fall) begin
							tx_reg <= {tx_reg[6:0], 1'b0};
							oe_reg <= ~tx_reg[6];
						end
					end
					I2C_RACK: begin
						if (scl_rise)
							acked_reg <= ~SDA_IN;
						else if (scl_fall)
							st <= I2C_IDLE;
					end
					default: st <= I2C_IDLE;
				endcase
			end
		end
	end

	// ==================================================
	// coherent byte pairs
	logic [7:0] pair_hi;
	logic [15:0] wr16;
	assign pair_hi = (hold_ok && hold_addr == {wr_addr[3:1], 1'b0}) ? hold_reg : rd_mux({wr_addr[3:1], 1'b0});
	assign wr16 = {pair_hi, wr_data};

	// a high byte written alone waits for its low byte, so the pair lands in one cycle
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			hold_reg <= 8'h00;
			hold_addr <= 4'h0;
			hold_ok <= 1'b0;
			snap_reg <= 8'h00;
			snap_addr <= 4'h0;
			snap_ok <= 1'b0;
		end else begin
			if (wr_pulse && !wr_addr[0]) begin
				hold_reg <= wr_data;
				hold_addr <= wr_addr;
				hold_ok <= 1'b1;
			end else if (wr_pulse)
				hold_ok <= 1'b0;
			if (load_byte && !ara_reg && !ptr_reg[0]) begin
				snap_reg <= rd_mux(ptr_reg | 4'h1);
				snap_addr <= ptr_reg | 4'h1;
				snap_ok <= 1'b1;
			end
		end
	end

	// ==================================================
	// control and limit registers
	logic mode_clr;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			ctrl_reg <= `CTRL_RST;
		else if (wr_pulse && wr_addr == `OFS_CTRL)
			ctrl_reg <= wr_data;
		else if (mode_clr)
			ctrl_reg[7:6] <= ADC_SLEEP;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			chi_reg <= `LIM16_HI_RST;
			clo_reg <= `LIM16_LO_RST;
			vhi_reg <= `LIM8_HI_RST;
			vlo_reg <= `LIM8_LO_RST;
			thi_reg <= `LIM8_HI_RST;
			tlo_reg <= `LIM8_LO_RST;
		end else if (wr_pulse) begin
			case (wr_addr)
				`OFS_CHI_L: chi_reg <= wr16;
				`OFS_CLO_L: clo_reg <= wr16;
				`OFS_VHI: vhi_reg <= wr_data;
				`OFS_VLO: vlo_reg <= wr_data;
				`OFS_THI: thi_reg <= wr_data;
				`OFS_TLO: tlo_reg <= wr_data;
				default: ;
			endcase
		end
	end

	// ==================================================
	// prescaler and charge counter
	logic [6:0] pre_reg, pre_top;
	logic up, count_en, wrap_up, wrap_dn, full_force, acr_wr;
	assign pre_top = 7'((8'h01 << ctrl_reg[5:3]) - 8'h01);
	assign up = SWITCH_ONE ~^ RAMP_UP;
	assign count_en = INTEG_STEP & ~shdn & ~UNDERVOLTAGE_LOCKOUT;
	assign wrap_up = count_en & up & pre_reg >= pre_top;
	assign wrap_dn = count_en & ~up & pre_reg == 7'h00;
	assign full_force = pin_mode == PIN_FULL && ALERT_IN;
	assign acr_wr = wr_pulse && wr_addr == `OFS_ACR_L;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pre_reg <= 7'h00;
			acr_reg <= `ACR_RST;
			sat_reg <= 1'b0;
		end else begin
			sat_reg <= 1'b0;
			if (shdn)
				pre_reg <= 7'h00;
			else if (wrap_up)
				pre_reg <= 7'h00;
			else if (wrap_dn)
				pre_reg <= pre_top;
			else if (count_en)
				pre_reg <= up ? pre_reg + 7'h01 : pre_reg - 7'h01;
			if (full_force)
				acr_reg <= `ACR_TOP;
			else if (acr_wr)
				acr_reg <= wr16;
			else if (wrap_up) begin
				if (acr_reg != `ACR_TOP)
					acr_reg <= acr_reg + 16'h0001;
				if (acr_reg >= 16'hfffe)
					sat_reg <= 1'b1;
			end else if (wrap_dn) begin
				if (acr_reg != `ACR_BOT)
					acr_reg <= acr_reg - 16'h0001;
				if (acr_reg <= 16'h0001)
					sat_reg <= 1'b1;
			end
		end
	end

	// ==================================================
	// status flags and alert pin
	logic [5:0] cond, trig, flags_next;
	assign cond[`ST_OVF] = acr_reg == `ACR_TOP || acr_reg == `ACR_BOT;
	assign cond[`ST_TEMP] = temp_reg[15:8] > thi_reg || temp_reg[15:8] < tlo_reg;
	assign cond[`ST_CHI] = acr_reg > chi_reg;
	assign cond[`ST_CLO] = acr_reg < clo_reg;
	assign cond[`ST_VOLT] = volt_reg[15:8] > vhi_reg || volt_reg[15:8] < vlo_reg;
	assign cond[`ST_UV] = UNDERVOLTAGE_LOCKOUT;
	assign trig = {sat_reg, cond[4:0]};
	// a flag whose cause is still present survives the read
	assign flags_next = status_rd ? (flags_reg & cond) | trig : flags_reg | trig;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			flags_reg <= 6'h00;
		else
			flags_reg <= flags_next;
	end

	// new flag wins over a release by the alert response in the same cycle
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			alert_reg <= 1'b0;
		else if (pin_mode != PIN_ALERT)
			alert_reg <= 1'b0;
		else if (|(flags_next & ~flags_reg))
			alert_reg <= 1'b1;
		else if (load_byte && ara_reg)
			alert_reg <= 1'b0;
	end

	assign ALERT_OE = alert_reg;
	assign ALERT_OUT = 1'b0;
	assign SDA_OE = oe_reg;
	assign SDA_OUT = 1'b0;

	// ==================================================
	// conversion sequencer
	conv_state_t cv;
	adc_mode_t started;
	logic [31:0] period_cnt;
	logic volt_done, temp_done;
	assign volt_done = cv == CV_VOLT && ADC_DONE;
	assign temp_done = cv == CV_TEMP && ADC_DONE;
	// cleared in the done cycle so the idle state never restarts a finished single shot
	assign mode_clr = (volt_done && started == ADC_VOLT1 && adc_mode == ADC_VOLT1)
		|| (temp_done && started == ADC_TEMP1 && adc_mode == ADC_TEMP1);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cv <= CV_IDLE;
			started <= ADC_SLEEP;
			period_cnt <= 32'h0;
			ADC_START <= 1'b0;
			ADC_TEMP <= 1'b0;
			volt_reg <= 16'h0000;
			temp_reg <= 16'h0000;
		end else begin
			ADC_START <= 1'b0;
			if (period_cnt != 32'hffffffff)
				period_cnt <= period_cnt + 32'h1;
			case (cv)
				CV_IDLE: begin
					if (!shdn && adc_mode != ADC_SLEEP) begin
						started <= adc_mode;
						ADC_START <= 1'b1;
						ADC_TEMP <= adc_mode == ADC_TEMP1;
						cv <= adc_mode == ADC_TEMP1 ? CV_TEMP : CV_VOLT;
						period_cnt <= 32'h0;
					end
				end
				CV_VOLT: begin
					if (ADC_DONE) begin
						volt_reg <= ADC_DATA;
						if (adc_mode == ADC_AUTO) begin
							ADC_START <= 1'b1;
							ADC_TEMP <= 1'b1;
							cv <= CV_TEMP;
						end else
							cv <= CV_IDLE;
					end
				end
				CV_TEMP: begin
					if (ADC_DONE) begin
						temp_reg <= ADC_DATA;
						cv <= adc_mode == ADC_AUTO ? CV_WAIT : CV_IDLE;
					end
				end
				CV_WAIT: begin
					if (adc_mode != ADC_AUTO || period_cnt >= AUTO_PERIOD_CYCLES - 1)
						cv <= CV_IDLE;
				end
				default: cv <= CV_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			ANALOG_OFF <= 1'b0;
		else
			ANALOG_OFF <= shdn | UNDERVOLTAGE_LOCKOUT;
	end

	// ==================================================
	// checks
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);

	chk_count_up: assert property (wrap_up && !full_force && !acr_wr && acr_reg != `ACR_TOP
		|=> acr_reg == $past(acr_reg) + 16'h0001) else $error("counter did not step up");
	chk_count_down: assert property (wrap_dn && !full_force && !acr_wr && acr_reg != `ACR_BOT
		|=> acr_reg == $past(acr_reg) - 16'h0001) else $error("counter did not step down");
	chk_sat_top: assert property (wrap_up && !acr_wr && acr_reg == `ACR_TOP
		|=> acr_reg == `ACR_TOP ##1 flags_reg[`ST_OVF]) else $error("counter wrapped at top");
	chk_full_force: assert property (full_force |=> acr_reg == `ACR_TOP) else $error("charge full ignored");
	chk_shdn_hold: assert property (shdn && !full_force && !acr_wr |=> $stable(acr_reg) && pre_reg == 7'h00)
		else $error("counted in shutdown");
	chk_read_keep: assert property (status_rd && cond[`ST_CHI] |=> flags_reg[`ST_CHI])
		else $error("persisting flag cleared");
	chk_clo_flag: assert property (acr_reg < clo_reg |=> flags_reg[`ST_CLO]) else $error("low charge flag missed");
	chk_alert_pull: assert property (pin_mode == PIN_ALERT && |(flags_next & ~flags_reg)
		|=> ALERT_OE) else $error("alert pin not pulled");
	chk_ara_release: assert property (load_byte && ara_reg && !(|(flags_next & ~flags_reg))
		|=> !ALERT_OE) else $error("alert not released");
	chk_single_clear: assert property (mode_clr && !(wr_pulse && wr_addr == `OFS_CTRL)
		|=> adc_mode == ADC_SLEEP ##1 cv == CV_IDLE) else $error("single shot not cleared");
	chk_auto_temp: assert property (volt_done && adc_mode == ADC_AUTO
		|=> ADC_START && ADC_TEMP && cv == CV_TEMP) else $error("auto temperature not started");
endmodule

// ===== core/charge_gauge_defines.svh
`ifndef CHARGE_GAUGE_DEFINES_SVH
`define CHARGE_GAUGE_DEFINES_SVH

// ==================================================
// bus addresses
`define DEV_ADDR 7'h64
`define ARA_ADDR 7'h0c
`define ARA_REPLY 8'hc8
// ==================================================
// register offsets
`define OFS_STATUS 4'h0
`define OFS_CTRL 4'h1
`define OFS_ACR_H 4'h2
`define OFS_ACR_L 4'h3
`define OFS_CHI_H 4'h4
`define OFS_CHI_L 4'h5
`define OFS_CLO_H 4'h6
`define OFS_CLO_L 4'h7
`define OFS_VOLT_H 4'h8
`define OFS_VOLT_L 4'h9
`define OFS_VHI 4'ha
`define OFS_VLO 4'hb
`define OFS_TEMP_H 4'hc
`define OFS_TEMP_L 4'hd
`define OFS_THI 4'he
`define OFS_TLO 4'hf
// ==================================================
// field positions
`define ST_OVF 5
`define ST_TEMP 4
`define ST_CHI 3
`define ST_CLO 2
`define ST_VOLT 1
`define ST_UV 0
`define SHDN_BIT 0
// ==================================================
// reset values and counter limits
`define CTRL_RST 8'h3c
`define ACR_RST 16'h7fff
`define LIM16_HI_RST 16'hffff
`define LIM16_LO_RST 16'h0000
`define LIM8_HI_RST 8'hff
`define LIM8_LO_RST 8'h00
`define ACR_TOP 16'hffff
`define ACR_BOT 16'h0000
// ==================================================
// timing
`define CLK_MHZ 100
`define AUTO_PERIOD_MS 2000
`define AUTO_PERIOD_CYC (`AUTO_PERIOD_MS * 1000 * `CLK_MHZ)
`endif

// ===== core/charge_gauge_pkg.sv
package charge_gauge_pkg;
	typedef enum logic [1:0] {PIN_OFF = 2'b00, PIN_FULL = 2'b01, PIN_ALERT = 2'b10, PIN_BAD = 2'b11} pin_mode_t;
	typedef enum logic [1:0] {ADC_SLEEP = 2'b00, ADC_TEMP1 = 2'b01, ADC_VOLT1 = 2'b10, ADC_AUTO = 2'b11} adc_mode_t;
	typedef enum logic [3:0] {
		I2C_IDLE = 4'b0000, I2C_ADDR = 4'b0001, I2C_AACK = 4'b0010, I2C_PTR = 4'b0011, I2C_PACK = 4'b0100,
		I2C_WDATA = 4'b0101, I2C_WACK = 4'b0110, I2C_RDATA = 4'b0111, I2C_RACK = 4'b1000
	} i2c_state_t;
	typedef enum logic [1:0] {CV_IDLE = 2'b00, CV_VOLT = 2'b01, CV_TEMP = 2'b10, CV_WAIT = 2'b11} conv_state_t;
endpackage

// ===== tb/i2c_host_model.sv
`timescale 1ns/1ns
module i2c_host_model (
	input wire logic clk,
	input wire logic sda_wire,
	output logic scl,
	output logic sda_low
);
	// ==================================================
	// bit level: the host owns the clock line
	localparam int HALF = 4;
	localparam logic [6:0] TARGET = 7'b1100100;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// data changes one clock after the clock line falls, never while it is high
	task automatic send_bit(input logic b);
		sda_low = ~b;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		scl = 1'b0;
		tick(1);
	endtask
	task automatic recv_bit(output logic b);
		sda_low = 1'b0;
		tick(HALF);
		scl = 1'b1;
		tick(2);
		b = sda_wire;
		tick(HALF - 2);
		scl = 1'b0;
		tick(1);
	endtask
	task automatic bus_start();
		sda_low = 1'b0;
		scl = 1'b1;
		tick(HALF);
		sda_low = 1'b1;
		tick(HALF);
		scl = 1'b0;
		tick(1);
	endtask
	task automatic bus_stop();
		sda_low = 1'b1;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_low = 1'b0;
		tick(HALF);
	endtask
	// ==================================================
	// byte level
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) send_bit(d[i]);
		recv_bit(a);
		ack = ~a;
	endtask
	task automatic recv_byte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) recv_bit(d[i]);
		send_bit(last);
	endtask
	task automatic open(input logic [6:0] a, input logic rd, output logic ack);
		bus_start();
		send_byte({a, rd}, ack);
	endtask
	// ==================================================
	// transfers
	task automatic probe(input logic [6:0] a, output logic ack);
		open(a, 1'b0, ack);
		bus_stop();
	endtask
	// the host only starts conversions by writing the control register
	task automatic write_regs(input logic [3:0] ptr, input int n, input logic [15:0] v, output logic ok);
		logic a;
		open(TARGET, 1'b0, ok);
		send_byte({4'h0, ptr}, a);
		ok = ok & a;
		if (n == 2) begin
			send_byte(v[15:8], a);
			ok = ok & a;
		end
		send_byte(v[7:0], a);
		ok = ok & a;
		bus_stop();
	endtask
	task automatic read_regs(input logic [3:0] ptr, input int n, output logic [7:0] q [16]);
		logic a;
		open(TARGET, 1'b0, a);
		send_byte({4'h0, ptr}, a);
		bus_stop();
		open(TARGET, 1'b1, a);
		for (int i = 0; i < n; i++) recv_byte(i == n - 1, q[i]);
		bus_stop();
	endtask
	task automatic alert_response(output logic ack, output logic [7:0] d);
		d = 8'h00;
		open(7'h0c, 1'b1, ack);
		if (ack) begin
			recv_byte(1'b1, d);
		end
		bus_stop();
	endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import charge_gauge_pkg::*;
	// ==================================================
	// bench signals
	localparam logic ID_BIT = 1'b1; // arbitrary identity value
	localparam logic [7:0] ID = {ID_BIT, 7'h00};
	localparam logic [7:0] C_RUN = {ADC_SLEEP, 3'b000, PIN_ALERT, 1'b0};
	logic clk, resetn, scl, sda_low, sda_wire, sda_out, sda_oe, alert_drv, alert_out, alert_oe;
	logic integ_step, switch_one, ramp_up, undervolt, adc_start, adc_temp, adc_done, analog_off;
	logic [15:0] adc_data, volt_val;
	logic [7:0] rbuf [16];
	int errors = 0;
	int n_compared = 0;
	int n_volt = 0;
	int n_temp = 0;
	int n_done = 0;
	assign sda_wire = ~(sda_low | sda_oe);
	charge_gauge_digital_core #(.AUTO_PERIOD_CYCLES(200), .CHIP_ID(ID_BIT)) uut (
		.CLK(clk), .RESETN(resetn), .SCL(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.ALERT_IN(alert_drv & ~alert_oe), .ALERT_OUT(alert_out), .ALERT_OE(alert_oe),
		.INTEG_STEP(integ_step), .SWITCH_ONE(switch_one), .RAMP_UP(ramp_up), .UNDERVOLTAGE_LOCKOUT(undervolt),
		.ADC_START(adc_start), .ADC_TEMP(adc_temp), .ADC_DONE(adc_done), .ADC_DATA(adc_data),
		.ANALOG_OFF(analog_off));
	i2c_host_model host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==================================================
	// converter stand-in: slow enough that a host write lands mid-conversion
	initial begin
		forever begin
			@(posedge clk);
			if (adc_start === 1'b1) begin
				if (adc_temp === 1'b1) n_temp++;
				else n_volt++;
				repeat (600) @(negedge clk);
				adc_data = adc_temp ? 16'h5678 : volt_val;
				adc_done = 1'b1;
				@(negedge clk);
				adc_done = 1'b0;
				adc_data = ~adc_data;
				n_done++;
			end
		end
	end
	// ==================================================
	// helpers
	task automatic stop_test();
		if (errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h got %h", what, exp, got);
		end
	endtask
	task automatic check_bit(input string what, input logic exp, input logic got);
		check_byte(what, {7'h00, exp}, {7'h00, got});
	endtask
	task automatic wait_done(input int tgt);
		for (int i = 0; i < 20000 && n_done < tgt; i++) @(negedge clk);
		if (n_done < tgt) begin
			check_byte("conversion count", tgt[7:0], n_done[7:0]);
			stop_test();
		end
	endtask
	task automatic wr(input logic [3:0] ptr, input int n, input logic [15:0] v);
		logic ok;
		host.write_regs(ptr, n, v, ok);
		check_bit("write ack", 1'b1, ok);
	endtask
	task automatic rd(input logic [3:0] ptr, input int n);
		host.read_regs(ptr, n, rbuf);
	endtask
	task automatic check_count(input logic [15:0] exp);
		rd(4'h2, 2);
		check_byte("counter high", exp[15:8], rbuf[0]);
		check_byte("counter low", exp[7:0], rbuf[1]);
	endtask
	task automatic step(input int n, input logic sw, input logic rp);
		switch_one = sw;
		ramp_up = rp;
		repeat (n) begin
			@(negedge clk);
			integ_step = 1'b1;
			@(negedge clk);
			integ_step = 1'b0;
		end
		@(negedge clk);
	endtask
	// ==================================================
	// scenarios
	task automatic t_reset();
		logic [7:0] exp [16] = '{ID, 8'h3c, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
			8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
		rd(4'h0, 16);
		for (int i = 0; i < 16; i++) check_byte("reset value", exp[i], rbuf[i]);
		wr(4'h8, 1, 16'h0055);
		wr(4'h0, 1, 16'h00ff);
		rd(4'h8, 1);
		check_byte("read-only result", 8'h00, rbuf[0]);
		rd(4'h0, 1);
		check_byte("status after write", ID, rbuf[0]);
		check_bit("data drive level", 1'b0, sda_out);
		check_bit("alert drive level", 1'b0, alert_out);
	endtask
	task automatic t_addr();
		logic ack;
		logic [7:0] d;
		host.probe(7'b1100101, ack);
		check_bit("other address ack", 1'b0, ack);
		host.alert_response(ack, d);
		check_bit("idle alert response ack", 1'b0, ack);
	endtask
	task automatic t_count();
		wr(4'h1, 1, {8'h00, C_RUN});
		wr(4'h2, 2, 16'h1000);
		step(3, 1'b1, 1'b1);
		step(2, 1'b0, 1'b0);
		step(1, 1'b1, 1'b0);
		check_count(16'h1004);
		wr(4'h1, 1, {8'h00, C_RUN | 8'h18});
		step(7, 1'b1, 1'b1);
		check_count(16'h1004);
		step(1, 1'b1, 1'b1);
		check_count(16'h1005);
		wr(4'h2, 1, 16'h0020);
		check_count(16'h1005);
		wr(4'h3, 1, 16'h0033);
		check_count(16'h2033);
	endtask
	task automatic t_flags();
		logic ack;
		logic [7:0] d;
		wr(4'h1, 1, {8'h00, C_RUN});
		wr(4'h4, 2, 16'h8000);
		wr(4'h2, 2, 16'hfffe);
		step(3, 1'b1, 1'b1);
		check_count(16'hffff);
		check_bit("alert pin", 1'b1, alert_oe);
		rd(4'h0, 1);
		check_byte("status at top", ID | 8'h28, rbuf[0]);
		wr(4'h2, 2, 16'h4000);
		rd(4'h0, 1);
		check_byte("status kept", ID | 8'h28, rbuf[0]);
		rd(4'h0, 1);
		check_byte("status cleared", ID, rbuf[0]);
		check_bit("alert held", 1'b1, alert_oe);
		host.alert_response(ack, d);
		check_bit("alert response ack", 1'b1, ack);
		check_byte("alert response byte", {7'b1100100, 1'b0}, d);
		check_bit("alert released", 1'b0, alert_oe);
		wr(4'h6, 2, 16'h3000);
		wr(4'h2, 2, 16'h0001);
		step(3, 1'b1, 1'b0);
		check_count(16'h0000);
		rd(4'h0, 1);
		check_byte("status at bottom", ID | 8'h24, rbuf[0]);
		wr(4'h6, 2, 16'h0000);
		wr(4'h4, 2, 16'hffff);
	endtask
	task automatic t_full();
		wr(4'h1, 1, {8'h00, ADC_SLEEP, 3'b000, PIN_FULL, 1'b0});
		alert_drv = 1'b1;
		repeat (5) @(negedge clk);
		alert_drv = 1'b0;
		check_bit("pin as input", 1'b0, alert_oe);
		check_count(16'hffff);
		wr(4'h2, 2, 16'h4000);
		wr(4'h1, 1, {8'h00, ADC_SLEEP, 3'b000, PIN_OFF, 1'b0});
		alert_drv = 1'b1;
		repeat (5) @(negedge clk);
		alert_drv = 1'b0;
		check_count(16'h4000);
	endtask
	task automatic t_adc();
		volt_val = 16'h1234;
		wr(4'h1, 1, {8'h00, ADC_VOLT1, 3'b000, PIN_ALERT, 1'b0});
		wait_done(1);
		rd(4'h8, 2);
		check_byte("voltage high", 8'h12, rbuf[0]);
		check_byte("voltage low", 8'h34, rbuf[1]);
		rd(4'h1, 1);
		check_byte("mode after voltage", C_RUN, rbuf[0]);
		wr(4'h1, 1, {8'h00, ADC_TEMP1, 3'b000, PIN_ALERT, 1'b0});
		wait_done(2);
		rd(4'hc, 2);
		check_byte("temperature high", 8'h56, rbuf[0]);
		check_byte("temperature low", 8'h78, rbuf[1]);
		rd(4'h1, 1);
		check_byte("mode after temperature", C_RUN, rbuf[0]);
		wr(4'ha, 1, 16'h0010);
		rd(4'h0, 1);
		check_bit("voltage flag", 1'b1, rbuf[0][1]);
		wr(4'ha, 1, 16'h00ff);
		volt_val = 16'h2222;
		wr(4'h1, 1, {8'h00, ADC_VOLT1, 3'b000, PIN_ALERT, 1'b0});
		wr(4'h1, 1, {8'h00, C_RUN});
		wait_done(3);
		rd(4'h8, 2);
		check_byte("voltage after mode change", 8'h22, rbuf[0]);
		wr(4'h1, 1, {8'h00, ADC_AUTO, 3'b000, PIN_ALERT, 1'b0});
		wait_done(7);
		check_byte("temperature starts", 8'd3, n_temp[7:0]);
		wr(4'h1, 1, {8'h00, C_RUN});
		wait_done(8);
		repeat (1300) @(negedge clk);
		check_byte("conversions after sleep", 8'd8, n_done[7:0]);
	endtask
	task automatic t_power();
		wr(4'h1, 1, {8'h00, C_RUN | 8'h01});
		check_bit("analog off", 1'b1, analog_off);
		step(3, 1'b1, 1'b1);
		check_count(16'h4000);
		wr(4'h1, 1, {8'h00, C_RUN | 8'h18});
		step(4, 1'b1, 1'b1);
		wr(4'h1, 1, {8'h00, C_RUN | 8'h19});
		wr(4'h1, 1, {8'h00, C_RUN | 8'h18});
		step(4, 1'b1, 1'b1);
		check_count(16'h4000);
		undervolt = 1'b1;
		step(3, 1'b1, 1'b1);
		rd(4'h0, 1);
		check_bit("undervoltage flag", 1'b1, rbuf[0][0]);
		check_bit("analog off on undervoltage", 1'b1, analog_off);
		undervolt = 1'b0;
		step(8, 1'b1, 1'b1);
		check_count(16'h4001);
	endtask
	// ==================================================
	// main sequence
	initial begin
		resetn = 1'b0;
		alert_drv = 1'b0;
		integ_step = 1'b0;
		switch_one = 1'b1;
		ramp_up = 1'b1;
		undervolt = 1'b0;
		adc_done = 1'b0;
		adc_data = 16'h0000;
		volt_val = 16'h0000;
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		t_reset();
		t_addr();
		t_count();
		t_flags();
		t_full();
		t_adc();
		t_power();
		stop_test();
	end
endmodule
